// ### inc/lmp_map.svh
/*
  Register indices, field positions, reset values and decode constants for
  the LCD-capable port and the multifunction port.
  Assumes a 32-bit APB slave: byte address = 4 * register index.
*/
`ifndef LMP_MAP_SVH
`define LMP_MAP_SVH

// register indices
`define LMP_IDX_LCD_DATA   10'h005
`define LMP_IDX_SHR_DATA   10'h006
`define LMP_IDX_LCD_DIR    10'h00B
`define LMP_IDX_SHR_DRV    10'h00C
`define LMP_IDX_SHR_PIN    10'h024
`define LMP_IDX_LCD_SEG    10'h02A
`define LMP_IDX_BIT_OP     10'h030
`define LMP_IDX_DRIVE_STAT 10'h031

// reset values
`define LMP_RST_LCD_DATA   8'h00
`define LMP_RST_LCD_DIR    8'h00
`define LMP_RST_LCD_SEG    8'h00
`define LMP_RST_SHR_DATA   8'hFF
`define LMP_RST_SHR_DRV    8'h00

// bit-op register fields
`define LMP_BOP_BIT_LSB    0
`define LMP_BOP_BIT_MSB    2
`define LMP_BOP_OP_LSB     3
`define LMP_BOP_OP_MSB     4
`define LMP_BOP_TARGET     5

// drive status fields
`define LMP_STAT_SHR_LSB   8

`endif

// ### inc/lmp_pkg.sv
/*
  Types shared by the port block: APB phase tracking and bit-op codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lmp_pkg;

  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_ACCESS = 1'b1
  } lmp_apb_e;

  typedef enum logic [1:0] {
    BOP_NONE  = 2'b00,
    BOP_SET   = 2'b01,
    BOP_CLEAR = 2'b10,
    BOP_TOGGLE = 2'b11
  } lmp_bitop_e;

  typedef logic [9:0] lmp_index_t;

endpackage : lmp_pkg

// ### hdl/lmp_lcd_pin.sv
/*
  One pin of the LCD-capable port: drive choice and read view.
  Assumes latch, direction and segment bits come from flip-flops.
*/
`timescale 1ns/1ps
module lmp_lcd_pin (
  input  wire logic latch_in,
  input  wire logic dir_in,
  input  wire logic seg_sel_in,
  input  wire logic seg_in,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_out,
  output logic      rd_out
);
  // segment wins over latch and direction
  assign pin_out    = seg_sel_in ? seg_in : latch_in;
  assign pin_oe_out = seg_sel_in | dir_in;

  // read view: latch, forced zero, or live pin
  assign rd_out = dir_in ? latch_in :
                  (seg_sel_in ? 1'b0 : pin_in);
endmodule : lmp_lcd_pin

// ### hdl/lmp_shr_pin.sv
/*
  One pin of the multifunction port: open-drain or push-pull drive.
  Assumes a peripheral that wants the pin raises periph_oe_in.
*/
`timescale 1ns/1ps
module lmp_shr_pin (
  input  wire logic latch_in,
  input  wire logic drv_sel_in,
  input  wire logic periph_out_in,
  input  wire logic periph_oe_in,
  output logic      pin_out,
  output logic      pin_oe_out
);
  logic val;

  // peripheral only gets through while the latch holds 1
  assign val = latch_in & (periph_oe_in ? periph_out_in : 1'b1);

  // open drain only ever sinks; a 1 leaves the wire to the pull-up
  assign pin_out    = drv_sel_in ? val : 1'b0;
  assign pin_oe_out = drv_sel_in | ~val;
endmodule : lmp_shr_pin

// ### hdl/lmp_ports.sv
/*
  APB slave holding the LCD-capable port and the multifunction port.
  Assumes an APB master on MCLK_IN, pins synchronous to MCLK_IN, an LCD
  segment driver on LCD_SEG_IN and shared peripherals on SHR_PERIPH_*.
*/
`timescale 1ns/1ps
`include "lmp_map.svh"
module lmp_ports
  import lmp_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int ADDR_W = 12
) (
  input  wire logic              MCLK_IN,
  input  wire logic              SYS_RST_IN,
  // apb slave
  input  wire logic              PSEL_IN,
  input  wire logic              PENABLE_IN,
  input  wire logic              PWRITE_IN,
  input  wire logic [ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]       PWDATA_IN,
  input  wire logic [3:0]        PSTRB_IN,
  output logic      [31:0]       PRDATA_OUT,
  output logic                   PREADY_OUT,
  output logic                   PSLVERR_OUT,
  // lcd-capable port
  input  wire logic [PORT_W-1:0] LCD_SEG_IN,
  input  wire logic [PORT_W-1:0] LCD_PIN_IN,
  output logic      [PORT_W-1:0] LCD_PIN_OUT,
  output logic      [PORT_W-1:0] LCD_PIN_OE_OUT,
  // multifunction port
  input  wire logic [PORT_W-1:0] SHR_PIN_IN,
  output logic      [PORT_W-1:0] SHR_PIN_OUT,
  output logic      [PORT_W-1:0] SHR_PIN_OE_OUT,
  input  wire logic [PORT_W-1:0] SHR_PERIPH_OUT_IN,
  input  wire logic [PORT_W-1:0] SHR_PERIPH_OE_IN,
  output logic      [PORT_W-1:0] SHR_PERIPH_LEVEL_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // bit-op selects a bit with a 3-bit field
  // status read packs both enable bytes, so PORT_W may not pass 8
  if (PORT_W < 1 || PORT_W > 8) begin : g_bad_width
    $error("lmp_ports: PORT_W must be 1 to 8");
  end
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
    $error("lmp_ports: ADDR_W must be 12 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // port registers
  logic [PORT_W-1:0] lcd_port_data_latch_q;
  logic [PORT_W-1:0] lcd_port_data_latch_d;
  logic [PORT_W-1:0] lcd_port_direction_q;
  logic [PORT_W-1:0] lcd_port_direction_d;
  logic [PORT_W-1:0] lcd_port_segment_select_q;
  logic [PORT_W-1:0] lcd_port_segment_select_d;
  logic [PORT_W-1:0] shared_port_data_latch_q;
  logic [PORT_W-1:0] shared_port_data_latch_d;
  logic [PORT_W-1:0] shared_port_drive_select_q;
  logic [PORT_W-1:0] shared_port_drive_select_d;

  // pin level fed to the shared peripherals
  logic [PORT_W-1:0] shr_level_q;

  // bus phase tracking
  lmp_apb_e          st_q;
  lmp_apb_e          st_d;
  logic              setup;
  logic              access;
  logic              wr_en;

  // address decode
  lmp_index_t        idx;
  logic              addr_aligned;
  logic              hit_lcd_data;
  logic              hit_shr_data;
  logic              hit_lcd_dir;
  logic              hit_shr_drv;
  logic              hit_shr_pin;
  logic              hit_lcd_seg;
  logic              hit_bit_op;
  logic              hit_stat;
  logic              hit_any;
  logic              hit_ro;
  logic              err_d;
  logic              err_q;

  // captured at setup, used at access
  logic [5:0]        hit_q;
  logic [PORT_W-1:0] cap_lcd_view_q;
  logic [31:0]       rd_mux;
  logic [31:0]       prdata_q;

  // per-pin views
  logic [PORT_W-1:0] lcd_view;
  logic [PORT_W-1:0] lcd_oe;
  logic [PORT_W-1:0] shr_oe;

  // bit-op
  logic [2:0]        bop_bit;
  lmp_bitop_e        bop_op;
  logic              bop_target;
  logic [PORT_W-1:0] bop_mask;
  logic [PORT_W-1:0] bop_base;
  logic [PORT_W-1:0] bop_res;
  logic              bop_lcd;
  logic              bop_shr;

  // upper address check and per-register write enables
  logic              hi_zero;
  logic              wr_lcd_data;
  logic              wr_shr_data;
  logic              wr_lcd_dir;
  logic              wr_shr_drv;
  logic              wr_lcd_seg;

  ////////////////////////////////////////////////////////////////////////////
  // pin slices

  for (genvar i = 0; i < PORT_W; i++) begin : g_lcd
    lmp_lcd_pin u_pin (
      .latch_in   (lcd_port_data_latch_q[i]),
      .dir_in     (lcd_port_direction_q[i]),
      .seg_sel_in (lcd_port_segment_select_q[i]),
      .seg_in     (LCD_SEG_IN[i]),
      .pin_in     (LCD_PIN_IN[i]),
      .pin_out    (LCD_PIN_OUT[i]),
      .pin_oe_out (lcd_oe[i]),
      .rd_out     (lcd_view[i])
    );
  end

  for (genvar i = 0; i < PORT_W; i++) begin : g_shr
    lmp_shr_pin u_pin (
      .latch_in      (shared_port_data_latch_q[i]),
      .drv_sel_in    (shared_port_drive_select_q[i]),
      .periph_out_in (SHR_PERIPH_OUT_IN[i]),
      .periph_oe_in  (SHR_PERIPH_OE_IN[i]),
      .pin_out       (SHR_PIN_OUT[i]),
      .pin_oe_out    (shr_oe[i])
    );
  end

  assign LCD_PIN_OE_OUT = lcd_oe;
  assign SHR_PIN_OE_OUT = shr_oe;

  // interrupt, wake-up, serial, uart, counter and boot inputs all tap here
  assign SHR_PERIPH_LEVEL_OUT = shr_level_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus phases

  assign setup  = PSEL_IN & ~PENABLE_IN;
  assign access = PSEL_IN & PENABLE_IN & (st_q == ST_ACCESS);
  assign st_d   = setup ? ST_ACCESS : ST_IDLE;

  // zero wait states: the access cycle always completes
  assign PREADY_OUT  = access;
  assign PSLVERR_OUT = access & err_q;
  assign PRDATA_OUT  = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  assign idx          = lmp_index_t'(PADDR_IN[ADDR_W-1:2]);
  assign addr_aligned = (PADDR_IN[1:0] == 2'h0);

  // the bit-op and status indices sit past the port registers
  assign hit_lcd_data = addr_aligned & (idx == `LMP_IDX_LCD_DATA);
  assign hit_shr_data = addr_aligned & (idx == `LMP_IDX_SHR_DATA);
  assign hit_lcd_dir  = addr_aligned & (idx == `LMP_IDX_LCD_DIR);
  assign hit_shr_drv  = addr_aligned & (idx == `LMP_IDX_SHR_DRV);
  assign hit_shr_pin  = addr_aligned & (idx == `LMP_IDX_SHR_PIN);
  assign hit_lcd_seg  = addr_aligned & (idx == `LMP_IDX_LCD_SEG);
  assign hit_bit_op   = addr_aligned & (idx == `LMP_IDX_BIT_OP);
  assign hit_stat     = addr_aligned & (idx == `LMP_IDX_DRIVE_STAT);

  // high address bits above the index must be zero too; a shift stays legal at ADDR_W = 12
  assign hi_zero = ((PADDR_IN >> 12) == '0);
  assign hit_any = hi_zero &
                   (hit_lcd_data | hit_shr_data | hit_lcd_dir |
                    hit_shr_drv | hit_shr_pin | hit_lcd_seg |
                    hit_bit_op | hit_stat);
  assign hit_ro  = hit_shr_pin | hit_stat;
  assign err_d   = ~hit_any | (PWRITE_IN & hit_ro);

  ////////////////////////////////////////////////////////////////////////////
  // read data, sampled in the setup cycle

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_any) begin
      if (hit_lcd_data) begin
        rd_mux[PORT_W-1:0] = lcd_view;
      end else if (hit_shr_data) begin
        rd_mux[PORT_W-1:0] = shared_port_data_latch_q;
      end else if (hit_lcd_dir) begin
        rd_mux[PORT_W-1:0] = lcd_port_direction_q;
      end else if (hit_shr_drv) begin
        rd_mux[PORT_W-1:0] = shared_port_drive_select_q;
      end else if (hit_shr_pin) begin
        rd_mux[PORT_W-1:0] = SHR_PIN_IN;
      end else if (hit_lcd_seg) begin
        rd_mux[PORT_W-1:0] = lcd_port_segment_select_q;
      end else if (hit_stat) begin
        rd_mux[PORT_W-1:0] = lcd_oe;
        rd_mux[`LMP_STAT_SHR_LSB +: PORT_W] = shr_oe;
      end else begin
        rd_mux = 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit-op: read-modify-write on a data address

  assign bop_bit    = PWDATA_IN[`LMP_BOP_BIT_MSB:`LMP_BOP_BIT_LSB];
  assign bop_op     = lmp_bitop_e'(PWDATA_IN[`LMP_BOP_OP_MSB:`LMP_BOP_OP_LSB]);
  assign bop_target = PWDATA_IN[`LMP_BOP_TARGET];
  assign bop_mask   = PORT_W'(1) << bop_bit;

  // lcd base is the read view taken at setup, so input bits pick up pins
  // segment-mode input bits read as 0, so a bit-op clears their latch bits
  assign bop_base = bop_target ? shared_port_data_latch_q : cap_lcd_view_q;

  always_comb begin
    case (bop_op)
      BOP_SET:    bop_res = bop_base | bop_mask;
      BOP_CLEAR:  bop_res = bop_base & ~bop_mask;
      BOP_TOGGLE: bop_res = bop_base ^ bop_mask;
      default:    bop_res = bop_base;
    endcase
  end

  assign bop_lcd = wr_en & hit_q[5] & ~bop_target & (bop_op != BOP_NONE);
  assign bop_shr = wr_en & hit_q[5] & bop_target & (bop_op != BOP_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // register next values

  // write lands at the end of the access cycle
  // only byte lane 0 holds a register, so the other strobes are ignored
  assign wr_en = access & PWRITE_IN & PSTRB_IN[0] & ~err_q;

  // one enable per register keeps the next-value muxes flat
  assign wr_lcd_data = wr_en & hit_q[0];
  assign wr_shr_data = wr_en & hit_q[1];
  assign wr_lcd_dir  = wr_en & hit_q[2];
  assign wr_shr_drv  = wr_en & hit_q[3];
  assign wr_lcd_seg  = wr_en & hit_q[4];

  assign lcd_port_data_latch_d =
    bop_lcd ? bop_res :
    wr_lcd_data ? PWDATA_IN[PORT_W-1:0] :
    lcd_port_data_latch_q;

  assign shared_port_data_latch_d =
    bop_shr ? bop_res :
    wr_shr_data ? PWDATA_IN[PORT_W-1:0] :
    shared_port_data_latch_q;

  assign lcd_port_direction_d =
    wr_lcd_dir ? PWDATA_IN[PORT_W-1:0] : lcd_port_direction_q;

  assign shared_port_drive_select_d =
    wr_shr_drv ? PWDATA_IN[PORT_W-1:0] : shared_port_drive_select_q;

  assign lcd_port_segment_select_d =
    wr_lcd_seg ? PWDATA_IN[PORT_W-1:0] : lcd_port_segment_select_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus state and captures

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_q  <= ST_IDLE;
      err_q <= 1'b0;
      hit_q <= 6'h00;
    end else begin
      st_q <= st_d;
      if (setup) begin
        err_q <= err_d;
        // bit order: bit-op, segment, drive, direction, shared data, lcd data
        hit_q <= {hit_bit_op, hit_lcd_seg, hit_shr_drv,
                  hit_lcd_dir, hit_shr_data, hit_lcd_data};
      end
    end
  end

  // pins are caught once, in the first cycle of the transfer
  // a pin that moves during the access cycle is not seen by this read
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      prdata_q       <= 32'h0000_0000;
      cap_lcd_view_q <= '0;
    end else if (setup) begin
      prdata_q       <= rd_mux;
      cap_lcd_view_q <= lcd_view;
    end
  end

  // one flop only: pins are taken as synchronous to the clock
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      shr_level_q <= '0;
    end else begin
      shr_level_q <= SHR_PIN_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port registers

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      lcd_port_data_latch_q     <= PORT_W'(`LMP_RST_LCD_DATA);
      lcd_port_direction_q      <= PORT_W'(`LMP_RST_LCD_DIR);
      lcd_port_segment_select_q <= PORT_W'(`LMP_RST_LCD_SEG);
    end else begin
      lcd_port_data_latch_q     <= lcd_port_data_latch_d;
      lcd_port_direction_q      <= lcd_port_direction_d;
      lcd_port_segment_select_q <= lcd_port_segment_select_d;
    end
  end

  // latch resets to ones so each open-drain pin starts released unless its peripheral drives 0
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      shared_port_data_latch_q   <= PORT_W'(`LMP_RST_SHR_DATA);
      shared_port_drive_select_q <= PORT_W'(`LMP_RST_SHR_DRV);
    end else begin
      shared_port_data_latch_q   <= shared_port_data_latch_d;
      shared_port_drive_select_q <= shared_port_drive_select_d;
    end
  end

endmodule : lmp_ports

// ### testbench/lmp_ports_chk.sv
/*
  Checker for the port block: bus answer timing, pin drive forms and reset state.
  Assumes it is bound into lmp_ports, with one clock and an asynchronous reset.
*/
`timescale 1ns/1ps
module lmp_ports_chk #(
  parameter int PORT_W = 8,
  parameter int ADDR_W = 12
) (
  input wire logic              MCLK_IN,
  input wire logic              SYS_RST_IN,
  input wire logic              PSEL_IN,
  input wire logic              PENABLE_IN,
  input wire logic              PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0]       PRDATA_OUT,
  input wire logic              PREADY_OUT,
  input wire logic              PSLVERR_OUT,
  input wire logic [PORT_W-1:0] LCD_PIN_OE_OUT,
  input wire logic [PORT_W-1:0] SHR_PIN_IN,
  input wire logic [PORT_W-1:0] SHR_PIN_OUT,
  input wire logic [PORT_W-1:0] SHR_PIN_OE_OUT,
  input wire logic [PORT_W-1:0] SHR_PERIPH_LEVEL_OUT
);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  ////////////////////////////////////////////////////////////////////////////////
  rdy_first_a: assert property (PSEL_IN && !PENABLE_IN ##1 PSEL_IN && PENABLE_IN |-> PREADY_OUT)
    else $error("no ready in first access cycle");
  idle_quiet_a: assert property (!(PSEL_IN && PENABLE_IN) |-> !PREADY_OUT && !PSLVERR_OUT)
    else $error("ready or error outside access");
  ro_write_a: assert property (PREADY_OUT && PWRITE_IN && PADDR_IN == 12'h090 |-> PSLVERR_OUT)
    else $error("pin state write not refused");
  rd_upper_a: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN != 12'h0C4 |-> PRDATA_OUT[31:8] == 24'h0)
    else $error("read data upper bits set");
  pin_read_a: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == 12'h090
    |-> PRDATA_OUT[PORT_W-1:0] == $past(SHR_PIN_IN))
    else $error("pin state not from setup cycle");
  level_dly_a: assert property (!$past(SYS_RST_IN) |-> SHR_PERIPH_LEVEL_OUT == $past(SHR_PIN_IN))
    else $error("peripheral level not one clock late");
  od_low_a: assert property ((SHR_PIN_OUT & ~SHR_PIN_OE_OUT) == '0)
    else $error("undriven shared pin shows high drive");
  rst_vals_a: assert property ($fell(SYS_RST_IN) |-> LCD_PIN_OE_OUT == '0 && SHR_PIN_OE_OUT == '0)
    else $error("pins driven straight after reset");
  // direction and segment only move after a completed write
  oe_hold_a: assert property (!$past(PSEL_IN && PENABLE_IN && PWRITE_IN) |-> $stable(LCD_PIN_OE_OUT))
    else $error("lcd enables moved without a write");
endmodule : lmp_ports_chk

bind lmp_ports lmp_ports_chk #(.PORT_W(PORT_W), .ADDR_W(ADDR_W)) lmp_ports_chk_inst (
  .MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .LCD_PIN_OE_OUT(LCD_PIN_OE_OUT), .SHR_PIN_IN(SHR_PIN_IN),
  .SHR_PIN_OUT(SHR_PIN_OUT), .SHR_PIN_OE_OUT(SHR_PIN_OE_OUT), .SHR_PERIPH_LEVEL_OUT(SHR_PERIPH_LEVEL_OUT));

// ### testbench/lmp_pin_model.sv
/*
  Pad model: resolves the levels of both ports' pins.
  Assumes an outside source always drives undriven LCD pads.
*/
`timescale 1ns/1ps
module lmp_pin_model (
  input  wire logic [7:0] lcd_drv_in,
  input  wire logic [7:0] lcd_oe_in,
  input  wire logic [7:0] lcd_ext_in,
  input  wire logic [7:0] shr_drv_in,
  input  wire logic [7:0] shr_oe_in,
  input  wire logic [7:0] shr_ext_en_in,
  input  wire logic [7:0] shr_ext_in,
  output logic      [7:0] lcd_level_out,
  output logic      [7:0] shr_level_out
);
  assign lcd_level_out = (lcd_oe_in & lcd_drv_in) | (~lcd_oe_in & lcd_ext_in);
  // released shared pads follow shr_ext_in where shr_ext_en_in is set, else rise through the board pull-up
  assign shr_level_out = (shr_oe_in & shr_drv_in)
                       | (~shr_oe_in & ((shr_ext_en_in & shr_ext_in) | ~shr_ext_en_in));
endmodule : lmp_pin_model

// ### testbench/tb_top.sv
/*
  Self-checking bench for the port block, with a pad model on its pins.
  Assumes a 250 MHz clock and the designer's zero-wait bus answer.
*/
`timescale 1ns/1ps
`include "lmp_map.svh"
module tb_top;
  localparam logic [11:0] a_ld  = {`LMP_IDX_LCD_DATA, 2'b00};
  localparam logic [11:0] a_sd  = {`LMP_IDX_SHR_DATA, 2'b00};
  localparam logic [11:0] a_dir = {`LMP_IDX_LCD_DIR, 2'b00};
  localparam logic [11:0] a_drv = {`LMP_IDX_SHR_DRV, 2'b00};
  localparam logic [11:0] a_ps  = {`LMP_IDX_SHR_PIN, 2'b00};
  localparam logic [11:0] a_seg = {`LMP_IDX_LCD_SEG, 2'b00};
  localparam logic [11:0] a_bop = {`LMP_IDX_BIT_OP, 2'b00};
  localparam logic [11:0] a_sts = {`LMP_IDX_DRIVE_STAT, 2'b00};
  logic        clk, rst, psel, pen, pwr, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  lcd_seg, lcd_pin, lcd_out, lcd_oe, lcd_ext, shr_pin, shr_out, shr_oe;
  logic [7:0]  p_out, p_oe, shr_lvl, ext_en, ext_val;
  int          n_fail, samples_checked, cycles;
  ////////////////////////////////////////////////////////////////////////////////
  lmp_ports lmp_ports_inst (.MCLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LCD_SEG_IN(lcd_seg), .LCD_PIN_IN(lcd_pin),
    .LCD_PIN_OUT(lcd_out), .LCD_PIN_OE_OUT(lcd_oe), .SHR_PIN_IN(shr_pin), .SHR_PIN_OUT(shr_out),
    .SHR_PIN_OE_OUT(shr_oe), .SHR_PERIPH_OUT_IN(p_out), .SHR_PERIPH_OE_IN(p_oe),
    .SHR_PERIPH_LEVEL_OUT(shr_lvl));
  lmp_pin_model lmp_pin_model_inst (.lcd_drv_in(lcd_out), .lcd_oe_in(lcd_oe), .lcd_ext_in(lcd_ext),
    .shr_drv_in(shr_out), .shr_oe_in(shr_oe), .shr_ext_en_in(ext_en), .shr_ext_in(ext_val),
    .lcd_level_out(lcd_pin), .shr_level_out(shr_pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // request held until pready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hF);
    chk(nm, rd, exp);
  endtask : rdc
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc("lcd view", a_ld, 32'h5A);
    rdc("lcd dir", a_dir, 32'h0);
    rdc("lcd seg", a_seg, 32'h0);
    rdc("shr latch", a_sd, 32'hFF);
    rdc("drive sel", a_drv, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_lcd;
    wr(a_ld, 32'hBC);
    wr(a_dir, 32'hF0);
    wr(a_seg, 32'hCC);
    @(negedge clk);
    chk("lcd oe", lcd_oe, 32'hFC);
    chk("lcd out", lcd_out & lcd_oe, 32'hB4);
    rdc("lcd view", a_ld, 32'hB2);
    lcd_seg <= 8'h69;
    @(negedge clk);
    chk("lcd seg follow", lcd_out & lcd_oe, 32'h78);
    $display("test lcd modes done");
  endtask : t_lcd
  task automatic t_bitop;
    logic [7:0] ops[4];
    logic [7:0] exps[4];
    ops = '{8'h27, 8'h3F, 8'h30, 8'h2F};
    exps = '{8'hFF, 8'h7F, 8'h7E, 8'hFE};
    wr(a_seg, 32'h0);
    wr(a_ld, 32'hFF);
    wr(a_dir, 32'h0F);
    wr(a_bop, 32'h09);
    wr(a_dir, 32'hFF);
    rdc("bitop lcd", a_ld, 32'h5F);
    chk("lcd drive", lcd_out, 32'h5F);
    for (int i = 0; i < 4; i++) begin
      wr(a_bop, {24'h0, ops[i]});
      rdc("bitop shr", a_sd, {24'h0, exps[i]});
    end
    $display("test bit ops done");
  endtask : t_bitop
  task automatic t_shared;
    wr(a_sd, 32'h0F);
    @(negedge clk);
    chk("od oe", shr_oe, 32'hF0);
    rdc("pins low", a_ps, 32'h0F);
    wr(a_drv, 32'hF0);
    wr(a_sd, 32'hFF);
    p_oe <= 8'h41;
    p_out <= 8'h00;
    @(negedge clk);
    chk("mix out", shr_out, 32'hB0);
    chk("mix oe", shr_oe, 32'hF1);
    @(negedge clk);
    chk("level", shr_lvl, 32'hBE);
    @(posedge clk);
    p_oe <= 8'h00;
    wr(a_drv, 32'h0);
    ext_en <= 8'hFF;
    ext_val <= 8'hA5;
    rdc("pin input", a_ps, 32'hA5);
    rdc("latch kept", a_sd, 32'hFF);
    ext_en <= 8'h00;
    $display("test shared port done");
  endtask : t_shared
  task automatic t_err;
    apb(1'b0, 12'h100, 32'h0, 4'hF);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b0, 12'h015, 32'h0, 4'hF);
    chk("misaligned err", er, 1'b1);
    apb(1'b1, a_ps, 32'h00, 4'hF);
    chk("ro write err", er, 1'b1);
    apb(1'b1, a_sd, 32'h00, 4'h0);
    chk("no strobe err", er, 1'b0);
    rdc("no strobe", a_sd, 32'hFF);
    rdc("drive status", a_sts, 32'h00FF);
    $display("test errors done");
  endtask : t_err
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, paddr, pwdata, pstrb} = '0;
    lcd_seg = 8'h96;
    lcd_ext = 8'h5A;
    {p_out, p_oe, ext_en, ext_val} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_lcd();
    t_bitop();
    t_shared();
    t_err();
    end_of_test();
  end
endmodule : tb_top
